// ===== core/dac_config_bank.sv
`timescale 1ns/1ps
`default_nettype none
module dac_config_bank (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    // register access from serial port framer
    input  wire logic                  regWrEn,
    input  wire logic                  regRdEn,
    input  wire logic [4:0]            regAddr,
    input  wire logic [7:0]            regWrData,
    output logic      [7:0]            regRdData,
    output logic                       regRdValid,
    // datapath and loop status
    input  wire logic [15:0]           lvdsDataIn,
    input  wire logic                  syncEvent,
    input  wire logic                  delayLockRaw,
    // datapath and loop controls
    output logic      [15:0]           lvdsDataOrdered,
    output logic                       dividerSync,
    output logic                       offsetSync,
    output logic                       holdSync,
    output logic                       delayLoopLocked,
    output dac_cfg_pkg::ctrl_type      ctrl,
    output dac_cfg_pkg::ratio_type     ratio
);
    logic [47:0] regsFlat;
    logic [2:0]  wrIdx;
    logic        wrHit;
    logic [2:0]  rdIdx;
    logic [7:0]  serialSync;
    logic [7:0]  powerBias;
    logic [7:0]  curScale;
    logic [7:0]  restartCtl;
    logic [7:0]  multDiv;
    logic [7:0]  dlyTune;

    // address to index
    always_comb begin
        wrHit = 1'b0;
        wrIdx = 3'h7;
        if (regAddr >= dac_cfg_pkg::ADDR_SERIAL_SYNC && regAddr <= dac_cfg_pkg::ADDR_DLY_TUNE) begin
            wrHit = 1'b1;
            wrIdx = 3'(regAddr - dac_cfg_pkg::ADDR_SERIAL_SYNC);
        end
        rdIdx = wrIdx;
    end

    cfg_reg_file u_regs (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .wrEn     (regWrEn && wrHit),
        .wrIdx    (wrIdx),
        .wrData   (regWrData),
        .rdIdx    (rdIdx),
        .rdData   (regRdData),
        .regsFlat (regsFlat)
    );

    assign {dlyTune, multDiv, restartCtl, curScale, powerBias, serialSync} = regsFlat;

    thermo_decode u_decode (
        .multCode (multDiv[7:3]),
        .divCode  (multDiv[2:0]),
        .ratio    (ratio)
    );

    // control decode
    logic [3:0] trim;
    always_comb begin
        trim = dlyTune[7:4];
        ctrl = '0;
        ctrl.fourWireSerial    = serialSync[dac_cfg_pkg::BIT_FOUR_WIRE];
        ctrl.busBitReverse     = serialSync[dac_cfg_pkg::BIT_BUS_REV];
        ctrl.dividerSyncEnable = !serialSync[dac_cfg_pkg::BIT_DIV_SYNC];
        ctrl.offsetSyncEnable  = !serialSync[dac_cfg_pkg::BIT_OFS_SYNC];
        ctrl.delayLoopSkip     = serialSync[dac_cfg_pkg::BIT_DLY_SKIP];
        ctrl.clockMultSkip     = serialSync[dac_cfg_pkg::BIT_MUL_SKIP];
        ctrl.holdSyncEnable    = !powerBias[dac_cfg_pkg::BIT_HOLD_SYNC];
        ctrl.chanASleep        = powerBias[dac_cfg_pkg::BIT_A_PD];
        ctrl.chanBSleep        = powerBias[dac_cfg_pkg::BIT_B_PD];
        ctrl.chanACornerHigh   = powerBias[dac_cfg_pkg::BIT_A_CORNER];
        ctrl.chanBCornerHigh   = powerBias[dac_cfg_pkg::BIT_B_CORNER];
        ctrl.multSleep         = powerBias[dac_cfg_pkg::BIT_MUL_SLEEP];
        ctrl.delaySleep        = powerBias[dac_cfg_pkg::BIT_DLY_SLEEP];
        ctrl.chanAScale        = {1'b0, curScale[7:4]} + 5'h01;
        ctrl.chanBScale        = {1'b0, curScale[3:0]} + 5'h01;
        ctrl.delayRestart      = restartCtl[dac_cfg_pkg::BIT_DLY_RESTART];
        ctrl.delayClockInvert  = dlyTune[dac_cfg_pkg::BIT_DLY_INV];
        ctrl.delayBias         = dlyTune[2:0];
        ctrl.delayBiasForbidden = (dlyTune[2:0] == dac_cfg_pkg::BIAS_FORBID);
        // signed trim: 90 degrees plus or minus 5 per step
        if (trim[3]) begin
            ctrl.delayPhaseDeg = dac_cfg_pkg::TRIM_BASE_DEG
                - 7'(({1'b0, ~trim[2:0]} + 4'h1) * dac_cfg_pkg::TRIM_STEP_DEG);
        end else begin
            ctrl.delayPhaseDeg = dac_cfg_pkg::TRIM_BASE_DEG
                + 7'(trim * dac_cfg_pkg::TRIM_STEP_DEG);
        end
    end

    // bus order swap
    genvar b;
    logic [15:0] dataNext;
    generate
        for (b = 0; b < 16; b++) begin : g_rev
            assign dataNext[b] = ctrl.busBitReverse ? lvdsDataIn[15-b] : lvdsDataIn[b];
        end
    endgenerate

    // registered outputs
    logic [15:0] dataReg;
    logic        divSyncNext;
    logic        ofsSyncNext;
    logic        holdSyncNext;
    logic        lockNext;
    logic        rdValidNext;
    logic        divSyncReg;
    logic        ofsSyncReg;
    logic        holdSyncReg;
    logic        lockReg;
    logic        rdValidReg;

    always_comb begin
        divSyncNext  = syncEvent && ctrl.dividerSyncEnable;
        ofsSyncNext  = syncEvent && ctrl.offsetSyncEnable;
        holdSyncNext = syncEvent && ctrl.holdSyncEnable;
        lockNext     = delayLockRaw && !ctrl.delayRestart && !ctrl.delaySleep;
        rdValidNext  = regRdEn;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            dataReg     <= 16'h0000;
            divSyncReg  <= 1'b0;
            ofsSyncReg  <= 1'b0;
            holdSyncReg <= 1'b0;
            lockReg     <= 1'b0;
            rdValidReg  <= 1'b0;
        end else begin
            dataReg     <= dataNext;
            divSyncReg  <= divSyncNext;
            ofsSyncReg  <= ofsSyncNext;
            holdSyncReg <= holdSyncNext;
            lockReg     <= lockNext;
            rdValidReg  <= rdValidNext;
        end
    end

    assign lvdsDataOrdered = dataReg;
    assign dividerSync     = divSyncReg;
    assign offsetSync      = ofsSyncReg;
    assign holdSync        = holdSyncReg;
    assign delayLoopLocked = lockReg;
    assign regRdValid      = rdValidReg;
endmodule
`default_nettype wire

// ===== core/dac_cfg_pkg.sv
// Contract
// - serial port runs four-pin when four_wire_serial_select is 1, three-pin when 0
// - bus_bit_reverse swaps input data bus lane order, MSB to LSB
// - divider_sync_disable blocks sync events to the clock divider
// - elastic_offset_sync_disable stops reloading buffer pointer offset on sync
// - delay_loop_skip bypasses data clock delay loop; source then owns timing
// - clock_multiplier_skip bypasses multiplier, reference clock used directly
// - hold_stage_sync_disable blocks sync to hold stage; host mirrors offset bit
// - each channel sleeps only on its own powerdown bit
// - bias corner bit 0 selects 95 kHz, 1 selects 472 kHz
// - multiplier sleep and delay sleep bits put those loops to sleep
// - four-bit current scale gives field plus one sixteenths; A upper, B lower
// - restart holds delay loop filter zero, line mid-range; clear reacquires
// - delay loop lock indicator cleared while restart is set
// - multiplier code is thermometer: M 1,2,4,8,16,32; others invalid
// - divider code is thermometer: N 1,2,4,8; others invalid
// - oscillator frequency equals reference times M divided by N
// - delay trim steps 5 degrees around 90; 1000 is 50, 0111 is 125
// - delay_clock_invert inverts internal delay loop clock
// - bias select 011 max bias, 000 mid, 101 min; 100 never used
package dac_cfg_pkg;
    localparam logic [4:0] ADDR_SERIAL_SYNC = 5'h05;
    localparam logic [4:0] ADDR_POWER_BIAS  = 5'h06;
    localparam logic [4:0] ADDR_CUR_SCALE   = 5'h07;
    localparam logic [4:0] ADDR_RESTART     = 5'h08;
    localparam logic [4:0] ADDR_MULT_DIV    = 5'h09;
    localparam logic [4:0] ADDR_DLY_TUNE    = 5'h0A;
    localparam int         NUM_REGS         = 6;

    localparam logic [7:0] RST_SERIAL_SYNC = 8'h00;
    localparam logic [7:0] RST_POWER_BIAS  = 8'h0C;
    localparam logic [7:0] RST_CUR_SCALE   = 8'hFF;
    localparam logic [7:0] RST_RESTART     = 8'h00;
    localparam logic [7:0] RST_MULT_DIV    = 8'h00;
    localparam logic [7:0] RST_DLY_TUNE    = 8'h00;

    // writable bits; reserved/unused bits read zero
    localparam logic [7:0] MASK_SERIAL_SYNC = 8'hF6;
    localparam logic [7:0] MASK_POWER_BIAS  = 8'hBF;
    localparam logic [7:0] MASK_CUR_SCALE   = 8'hFF;
    localparam logic [7:0] MASK_RESTART     = 8'h08;
    localparam logic [7:0] MASK_MULT_DIV    = 8'hFF;
    localparam logic [7:0] MASK_DLY_TUNE    = 8'hFF;

    localparam int BIT_FOUR_WIRE   = 7;
    localparam int BIT_BUS_REV     = 6;
    localparam int BIT_DIV_SYNC    = 5;
    localparam int BIT_OFS_SYNC    = 4;
    localparam int BIT_DLY_SKIP    = 2;
    localparam int BIT_MUL_SKIP    = 1;
    localparam int BIT_HOLD_SYNC   = 7;
    localparam int BIT_B_PD        = 5;
    localparam int BIT_A_PD        = 4;
    localparam int BIT_A_CORNER    = 3;
    localparam int BIT_B_CORNER    = 2;
    localparam int BIT_MUL_SLEEP   = 1;
    localparam int BIT_DLY_SLEEP   = 0;
    localparam int BIT_DLY_RESTART = 3;
    localparam int BIT_DLY_INV     = 3;

    localparam int CORNER_LOW_KHZ  = 95;
    localparam int CORNER_HIGH_KHZ = 472;
    localparam logic [6:0] TRIM_BASE_DEG = 7'h5A;
    localparam logic [6:0] TRIM_STEP_DEG = 7'h05;
    localparam logic [2:0] BIAS_MAX      = 3'h3;
    localparam logic [2:0] BIAS_MID      = 3'h0;
    localparam logic [2:0] BIAS_MIN      = 3'h5;
    localparam logic [2:0] BIAS_FORBID   = 3'h4;

    typedef struct packed {
        logic       fourWireSerial;
        logic       busBitReverse;
        logic       dividerSyncEnable;
        logic       offsetSyncEnable;
        logic       holdSyncEnable;
        logic       delayLoopSkip;
        logic       clockMultSkip;
        logic       chanASleep;
        logic       chanBSleep;
        logic       chanACornerHigh;
        logic       chanBCornerHigh;
        logic       multSleep;
        logic       delaySleep;
        logic [4:0] chanAScale;
        logic [4:0] chanBScale;
        logic       delayRestart;
        logic       delayClockInvert;
        logic [2:0] delayBias;
        logic       delayBiasForbidden;
        logic [6:0] delayPhaseDeg;
    } ctrl_type;

    typedef struct packed {
        logic [5:0] multM;
        logic       multValid;
        logic [3:0] divN;
        logic       divValid;
    } ratio_type;
endpackage

// ===== core/thermo_decode.sv
`timescale 1ns/1ps
`default_nettype none
module thermo_decode (
    // codes
    input  wire logic [4:0]           multCode,
    input  wire logic [2:0]           divCode,
    // decoded ratio
    output dac_cfg_pkg::ratio_type    ratio
);
    always_comb begin
        ratio = '0;
        case (multCode)
            5'h00: ratio.multM = 6'h01;
            5'h01: ratio.multM = 6'h02;
            5'h03: ratio.multM = 6'h04;
            5'h07: ratio.multM = 6'h08;
            5'h0F: ratio.multM = 6'h10;
            5'h1F: ratio.multM = 6'h20;
            default: ratio.multM = 6'h00;
        endcase
        ratio.multValid = (ratio.multM != 6'h00);
        case (divCode)
            3'h0: ratio.divN = 4'h1;
            3'h1: ratio.divN = 4'h2;
            3'h3: ratio.divN = 4'h4;
            3'h7: ratio.divN = 4'h8;
            default: ratio.divN = 4'h0;
        endcase
        ratio.divValid = (ratio.divN != 4'h0);
    end
endmodule
`default_nettype wire

// ===== core/cfg_reg_file.sv
`timescale 1ns/1ps
`default_nettype none
module cfg_reg_file (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // access
    input  wire logic       wrEn,
    input  wire logic [2:0] wrIdx,
    input  wire logic [7:0] wrData,
    input  wire logic [2:0] rdIdx,
    output logic      [7:0] rdData,
    // flat contents
    output logic      [47:0] regsFlat
);
    localparam logic [47:0] RST_ALL = {dac_cfg_pkg::RST_DLY_TUNE, dac_cfg_pkg::RST_MULT_DIV,
        dac_cfg_pkg::RST_RESTART, dac_cfg_pkg::RST_CUR_SCALE,
        dac_cfg_pkg::RST_POWER_BIAS, dac_cfg_pkg::RST_SERIAL_SYNC};
    localparam logic [47:0] MASK_ALL = {dac_cfg_pkg::MASK_DLY_TUNE, dac_cfg_pkg::MASK_MULT_DIV,
        dac_cfg_pkg::MASK_RESTART, dac_cfg_pkg::MASK_CUR_SCALE,
        dac_cfg_pkg::MASK_POWER_BIAS, dac_cfg_pkg::MASK_SERIAL_SYNC};

    logic [47:0] regsReg;
    logic [47:0] regsNext;
    logic [7:0]  rdDataNext;

    genvar i;
    generate
        for (i = 0; i < dac_cfg_pkg::NUM_REGS; i++) begin : g_reg
            always_comb begin
                regsNext[i*8 +: 8] = regsReg[i*8 +: 8];
                if (wrEn && wrIdx == 3'(i)) begin
                    // reserved and unused bits ignore writes
                    regsNext[i*8 +: 8] = wrData & MASK_ALL[i*8 +: 8];
                end
            end
        end
    endgenerate

    always_comb begin
        rdDataNext = 8'h00;
        if (rdIdx < 3'(dac_cfg_pkg::NUM_REGS)) begin
            rdDataNext = regsReg[rdIdx*8 +: 8];
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            regsReg <= RST_ALL;
            rdData  <= 8'h00;
        end else begin
            regsReg <= regsNext;
            rdData  <= rdDataNext;
        end
    end

    assign regsFlat = regsReg;
endmodule
`default_nettype wire

// ===== tb/dac_config_bank_chk.sv
`timescale 1ns/1ps
`default_nettype none
module dac_config_bank_chk (
    // clock and reset
    input wire logic                   clk,
    input wire logic                   sys_rst,
    // register access
    input wire logic                   regWrEn,
    input wire logic                   regRdEn,
    input wire logic [4:0]             regAddr,
    input wire logic [7:0]             regWrData,
    input wire logic [7:0]             regRdData,
    input wire logic                   regRdValid,
    // datapath and loop
    input wire logic [15:0]            lvdsDataIn,
    input wire logic                   syncEvent,
    input wire logic                   delayLockRaw,
    input wire logic [15:0]            lvdsDataOrdered,
    input wire logic                   dividerSync,
    input wire logic                   offsetSync,
    input wire logic                   holdSync,
    input wire logic                   delayLoopLocked,
    input wire dac_cfg_pkg::ctrl_type  ctrl,
    input wire dac_cfg_pkg::ratio_type ratio
);
    wire logic wrSer = regWrEn && regAddr == dac_cfg_pkg::ADDR_SERIAL_SYNC;
    wire logic wrRst = regWrEn && regAddr == dac_cfg_pkg::ADDR_RESTART;
    wire logic wrMd  = regWrEn && regAddr == dac_cfg_pkg::ADDR_MULT_DIV;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    function automatic logic [15:0] rev(input logic [15:0] d);
        for (int i = 0; i < 16; i++) begin
            rev[i] = d[15 - i];
        end
    endfunction
    // thermometer code valid when code plus one is a power of two
    function automatic logic [6:0] mdec(input logic [4:0] c);
        mdec = (((c + 5'h01) & c) == 5'h00) ? {1'b1, {1'b0, c} + 6'h01} : 7'h00;
    endfunction
    function automatic logic [4:0] ndec(input logic [2:0] c);
        ndec = (((c + 3'h1) & c) == 3'h0) ? {1'b1, {1'b0, c} + 4'h1} : 5'h00;
    endfunction

    AST_FOUR_WIRE: assert property (wrSer |=> ctrl.fourWireSerial == $past(regWrData[7]))
        else $error("pin mode select not taken from write");
    AST_BUS_ORDER: assert property (
        lvdsDataOrdered == ($past(ctrl.busBitReverse) ? rev($past(lvdsDataIn)) : $past(lvdsDataIn)))
        else $error("input bus lane order wrong");
    AST_DIV_SYNC: assert property (
        wrSer ##2 syncEvent |=> dividerSync == !$past(regWrData[5], 3))
        else $error("divider sync gating wrong");
    AST_OFS_SYNC: assert property (offsetSync == ($past(syncEvent) && $past(ctrl.offsetSyncEnable)))
        else $error("offset sync gating wrong");
    AST_HOLD_SYNC: assert property (holdSync == ($past(syncEvent) && $past(ctrl.holdSyncEnable)))
        else $error("hold stage sync gating wrong");
    AST_LOCK: assert property (
        delayLoopLocked == $past(delayLockRaw && !ctrl.delayRestart && !ctrl.delaySleep))
        else $error("lock indicator wrong");
    AST_RESTART: assert property (wrRst && regWrData[3] |=> ctrl.delayRestart ##1 !delayLoopLocked)
        else $error("restart did not clear lock");
    AST_MULT: assert property (wrMd |=> {ratio.multValid, ratio.multM} == mdec($past(regWrData[7:3])))
        else $error("multiplier decode wrong");
    AST_DIV: assert property (wrMd |=> {ratio.divValid, ratio.divN} == ndec($past(regWrData[2:0])))
        else $error("divider decode wrong");
endmodule
`default_nettype wire

// ===== tb/cfg_host.sv
`timescale 1ns/1ps
`default_nettype none
module cfg_host (
    // clock
    input  wire logic       clk,
    // register access
    output logic            regWrEn,
    output logic            regRdEn,
    output logic      [4:0] regAddr,
    output logic      [7:0] regWrData,
    input  wire logic [7:0] regRdData,
    input  wire logic       regRdValid
);
    initial begin
        regWrEn   = 1'b0;
        regRdEn   = 1'b0;
        regAddr   = 5'h00;
        regWrData = 8'h00;
    end
    // released lines show the inverse of the last value
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk);
        regWrEn   <= 1'b1;
        regAddr   <= a;
        regWrData <= d;
        @(posedge clk);
        regWrEn   <= 1'b0;
        regAddr   <= ~a;
        regWrData <= ~d;
        #1;
    endtask
    task automatic rd(input logic [4:0] a, output logic [7:0] d, output logic v);
        @(posedge clk);
        regRdEn <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRdEn <= 1'b0;
        regAddr <= ~a;
        #1;
        d = regRdData;
        v = regRdValid;
    endtask
    task automatic restart();
        wr(5'h08, 8'h08);
        wr(5'h08, 8'h00);
    endtask
endmodule
`default_nettype wire

// ===== tb/dac_config_bank_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dac_config_bank_tb;
    logic clk, sys_rst, regWrEn, regRdEn, regRdValid, syncEvent, delayLockRaw, vld;
    logic dividerSync, offsetSync, holdSync, delayLoopLocked;
    logic [4:0]             regAddr;
    logic [7:0]             regWrData, regRdData, rdv;
    logic [15:0]            lvdsDataIn, lvdsDataOrdered;
    dac_cfg_pkg::ctrl_type  ctrl;
    dac_cfg_pkg::ratio_type ratio;
    int                     err_total;
    int                     num_checks;
    logic [7:0]  rstv [6] = '{8'h00, 8'h0C, 8'hFF, 8'h00, 8'h00, 8'h00};
    logic [7:0]  maskv [6] = '{8'hF6, 8'hBF, 8'hFF, 8'h08, 8'hFF, 8'hFF};
    logic [4:0]  mc [7] = '{5'h00, 5'h01, 5'h03, 5'h07, 5'h0F, 5'h1F, 5'h02};
    logic [5:0]  me [7] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h00};
    logic [2:0]  nc [5] = '{3'h0, 3'h1, 3'h3, 3'h7, 3'h2};
    logic [3:0]  ne [5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h0};
    logic [7:0]  tc [3] = '{8'h80, 8'h7B, 8'h0D};
    logic [10:0] te [3] = '{{7'h32, 4'h0}, {7'h7D, 4'hB}, {7'h5A, 4'hD}};
    wire logic [6:0] c5 = {ctrl.fourWireSerial, ctrl.busBitReverse, ctrl.dividerSyncEnable,
        ctrl.offsetSyncEnable, ctrl.holdSyncEnable, ctrl.delayLoopSkip, ctrl.clockMultSkip};
    wire logic [5:0] c6 = {ctrl.chanASleep, ctrl.chanBSleep, ctrl.chanACornerHigh,
        ctrl.chanBCornerHigh, ctrl.multSleep, ctrl.delaySleep};
    wire logic [10:0] tn = {ctrl.delayPhaseDeg, ctrl.delayClockInvert, ctrl.delayBias};

    dac_config_bank i_dac_config_bank (.clk(clk), .sys_rst(sys_rst), .regWrEn(regWrEn),
        .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
        .regRdValid(regRdValid), .lvdsDataIn(lvdsDataIn), .syncEvent(syncEvent),
        .delayLockRaw(delayLockRaw), .lvdsDataOrdered(lvdsDataOrdered),
        .dividerSync(dividerSync), .offsetSync(offsetSync), .holdSync(holdSync),
        .delayLoopLocked(delayLoopLocked), .ctrl(ctrl), .ratio(ratio));
    cfg_host i_cfg_host (.clk(clk), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
        .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid));

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rchk(input logic [4:0] a, input logic [7:0] e);
        i_cfg_host.rd(a, rdv, vld);
        chk("regRdData", {8'h00, e}, {8'h00, rdv});
        chk("regRdValid", 16'h0001, {15'h0000, vld});
    endtask
    task automatic pulse(input logic [2:0] es, input logic [15:0] ed, input logic el);
        @(posedge clk);
        syncEvent  <= 1'b1;
        lvdsDataIn <= 16'h0001;
        @(posedge clk);
        syncEvent  <= 1'b0;
        lvdsDataIn <= 16'hFFFE;
        #1;
        chk("syncs", {13'h0000, es}, {13'h0000, dividerSync, offsetSync, holdSync});
        chk("lvdsDataOrdered", ed, lvdsDataOrdered);
        chk("delayLoopLocked", {15'h0000, el}, {15'h0000, delayLoopLocked});
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        test_done();
    end
    initial begin
        sys_rst      = 1'b1;
        lvdsDataIn   = 16'h0000;
        syncEvent    = 1'b0;
        delayLockRaw = 1'b0;
        err_total    = 0;
        num_checks   = 0;
        repeat (16) @(posedge clk);
        sys_rst      <= 1'b0;
        delayLockRaw <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            rchk(5'(5 + i), rstv[i]);
        end
        i_cfg_host.wr(5'h0B, 8'hFF);
        rchk(5'h0B, 8'h00);
        rchk(5'h04, 8'h00);
        for (int i = 0; i < 6; i++) begin
            // reserved bits kept zero; unused power-and-bias bit written high
            i_cfg_host.wr(5'(5 + i), maskv[i] | (i == 1 ? 8'h40 : 8'h00));
            rchk(5'(5 + i), maskv[i]);
            i_cfg_host.wr(5'(5 + i), 8'h00);
            rchk(5'(5 + i), 8'h00);
        end
        $display("register access test done");
        i_cfg_host.wr(5'h06, 8'hBF);
        i_cfg_host.wr(5'h05, 8'hF6);
        chk("ctrl05", 16'h0063, {9'h000, c5});
        chk("ctrl06", 16'h003F, {10'h000, c6});
        pulse(3'b000, 16'h8000, 1'b0);
        i_cfg_host.wr(5'h06, 8'h0C);
        i_cfg_host.wr(5'h05, 8'h00);
        chk("ctrl05", 16'h001C, {9'h000, c5});
        chk("ctrl06", 16'h000C, {10'h000, c6});
        pulse(3'b111, 16'h0001, 1'b1);
        i_cfg_host.wr(5'h06, 8'h10);
        chk("sleepA", 16'h0020, {10'h000, c6});
        i_cfg_host.wr(5'h06, 8'h20);
        chk("sleepB", 16'h0010, {10'h000, c6});
        i_cfg_host.wr(5'h08, 8'h08);
        @(posedge clk);
        #1;
        chk("lockInRestart", 16'h0000, {15'h0000, delayLoopLocked});
        i_cfg_host.wr(5'h08, 8'h00);
        @(posedge clk);
        #1;
        chk("lockAfterRestart", 16'h0001, {15'h0000, delayLoopLocked});
        $display("control test done");
        for (int i = 0; i < 7; i++) begin
            i_cfg_host.wr(5'h09, {mc[i], nc[i % 5]});
            chk("ratio", {4'h0, me[i], i < 6, ne[i % 5], i % 5 < 4}, {4'h0, ratio});
        end
        i_cfg_host.wr(5'h07, 8'h0F);
        chk("scale", 16'h0030, {6'h00, ctrl.chanAScale, ctrl.chanBScale});
        for (int i = 0; i < 3; i++) begin
            i_cfg_host.wr(5'h0A, tc[i]);
            chk("tune", {5'h00, te[i]}, {5'h00, tn});
            chk("biasForbid", 16'h0000, {15'h0000, ctrl.delayBiasForbidden});
            i_cfg_host.restart();
        end
        $display("decode test done");
        test_done();
    end
endmodule

bind dac_config_bank dac_config_bank_chk i_chk (.clk(clk), .sys_rst(sys_rst),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData),
    .regRdData(regRdData), .regRdValid(regRdValid), .lvdsDataIn(lvdsDataIn),
    .syncEvent(syncEvent), .delayLockRaw(delayLockRaw), .lvdsDataOrdered(lvdsDataOrdered),
    .dividerSync(dividerSync), .offsetSync(offsetSync), .holdSync(holdSync),
    .delayLoopLocked(delayLoopLocked), .ctrl(ctrl), .ratio(ratio));
`default_nettype wire
